// File: logic/cdm_consts.vh
// Purpose: Shared constants of the capture DMA instruction sequencer
// Assumes: Included by bare name from every design file
// Notes: Definitions only
`ifndef CDM_CONSTS_VH
`define CDM_CONSTS_VH
// Opcodes
`define CDM_OP_WRITE 4'h1
`define CDM_OP_SKIP 4'h2
`define CDM_OP_CONT 4'h5
`define CDM_OP_JUMP 4'h7
`define CDM_OP_SYNC 4'h8
`define CDM_OP_PWRITE 4'h9
`define CDM_OP_PSKIP 4'hA
`define CDM_OP_LWCS 4'hB
// Instruction word fields
`define CDM_F_OP 31:28
`define CDM_F_CNT 11:0
`define CDM_F_CNT3 27:16
`define CDM_F_BE 15:12
`define CDM_F_SET 19:16
`define CDM_F_CLR 23:20
`define CDM_F_STAT 3:0
`define CDM_B_IRQ 24
`define CDM_B_EOL 26
`define CDM_B_SOL 27
`define CDM_B_REALIGN 15
// FIFO status codes
`define CDM_ST_PACKED 4'h6
`define CDM_ST_PLANAR 4'hE
`define CDM_ST_SOL 4'h2
`define CDM_ST_EVEN_END 4'h4
`define CDM_ST_ODD_END 4'hC
`define CDM_ST_PLAIN 4'h0
`define CDM_ST_EOL_MASK 2'h1
// Channel modes
`define CDM_M_SKIP 2'h0
`define CDM_M_WRITE 2'h1
`define CDM_M_SYNC 2'h2
// Register offsets
`define CDM_REG_CTRL 4'h0
`define CDM_REG_START 4'h4
`define CDM_REG_STATUS 4'h8
`define CDM_REG_PC 4'hC
// Reset values
`define CDM_RST_START 32'h00000000
`define CDM_RST_PSB 4'h0
`endif

// File: logic/cdm_fetch.v
// Purpose: One-word instruction fetch through the PCI initiator
// Assumes: Initiator holds i_ack high one cycle with the word
// Notes: Request stays up until acknowledged
`include "cdm_consts.vh"
`default_nettype none
module cdm_fetch (
    // Clock and reset
    input wire i_mclk,
    input wire i_rst,
    // Sequencer side
    input wire i_go,
    input wire [31:0] i_addr,
    output reg [31:0] o_word,
    output reg o_done,
    // Initiator side
    output reg o_req,
    output reg [31:0] o_addr,
    input wire i_ack,
    input wire [31:0] i_data
);
    // Hold request until the initiator returns the word
    always @(posedge i_mclk) begin
        if (i_rst) begin
            o_req <= 1'b0;
            o_addr <= 32'h00000000;
            o_word <= 32'h00000000;
            o_done <= 1'b0;
        end else begin
            o_done <= 1'b0;
            if (i_go) begin
                o_req <= 1'b1;
                o_addr <= {i_addr[31:2], 2'h0};
            end else if (o_req && i_ack) begin
                o_req <= 1'b0;
                o_word <= i_data;
                o_done <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// File: logic/cdm_chan.v
// Purpose: One FIFO channel: write, skip or sync at byte resolution
// Assumes: FIFO head is valid data; o_pop removes the head word
// Notes: Steps every other cycle since pop comes from a flop
`include "cdm_consts.vh"
`default_nettype none
module cdm_chan #(
    parameter CW = 12
) (
    // Clock and reset
    input wire i_mclk,
    input wire i_rst,
    // Command
    input wire i_start,
    input wire [1:0] i_mode,
    input wire [CW-1:0] i_count,
    input wire i_load_addr,
    input wire [31:0] i_addr,
    input wire [3:0] i_be,
    input wire [3:0] i_target,
    input wire i_abort,
    // FIFO head
    input wire i_valid,
    input wire [31:0] i_data,
    input wire [3:0] i_status,
    output reg o_pop,
    // Write request
    output reg o_wr_valid,
    output reg [31:0] o_wr_addr,
    output reg [31:0] o_wr_data,
    output reg [3:0] o_wr_be,
    input wire i_wr_ready,
    // State
    output wire o_busy,
    output reg o_early
);
    reg busy_q;
    reg [1:0] mode_q;
    reg [CW-1:0] rem_q;
    reg [31:0] addr_q;
    reg [1:0] off_q;
    wire eol_w;
    wire [2:0] lim_w;
    wire [2:0] avail_w;
    wire [2:0] n_w;
    wire [2:0] end_w;

    function [2:0] valid_bytes;
        input [3:0] s;
        begin
            case (s[3:2])
                2'h0: valid_bytes = 3'h4;
                2'h3: valid_bytes = 3'h3;
                2'h2: valid_bytes = 3'h2;
                default: valid_bytes = 3'h1;
            endcase
        end
    endfunction

    // Byte lanes from offset for a count
    function [3:0] lanes;
        input [1:0] off;
        input [2:0] n;
        reg [7:0] m;
        begin
            m = (8'h01 << n) - 8'h01;
            m = m << off;
            lanes = m[3:0];
        end
    endfunction

    // Bytes taken this step, ending mid-word where needed
    assign eol_w = (i_status[1:0] == `CDM_ST_EOL_MASK);
    assign lim_w = eol_w ? valid_bytes(i_status) : 3'h4;
    assign avail_w = lim_w - {1'b0, off_q};
    assign n_w = (rem_q < {{(CW-3){1'b0}}, avail_w}) ? rem_q[2:0] : avail_w;
    assign end_w = {1'b0, off_q} + n_w;
    assign o_busy = busy_q | o_wr_valid;

    // Channel sequencing
    always @(posedge i_mclk) begin
        if (i_rst) begin
            busy_q <= 1'b0;
            mode_q <= `CDM_M_SKIP;
            rem_q <= {CW{1'b0}};
            addr_q <= 32'h00000000;
            off_q <= 2'h0;
            o_pop <= 1'b0;
            o_wr_valid <= 1'b0;
            o_wr_addr <= 32'h00000000;
            o_wr_data <= 32'h00000000;
            o_wr_be <= 4'h0;
            o_early <= 1'b0;
        end else begin
            o_pop <= 1'b0;
            o_early <= 1'b0;
            if (i_start) begin
                mode_q <= i_mode;
                rem_q <= i_count;
                busy_q <= (i_mode == `CDM_M_SYNC) || (i_count != {CW{1'b0}});
                if (i_load_addr) begin
                    addr_q <= i_addr;
                    off_q <= i_addr[1:0];
                end
            end else if (i_abort) begin
                // Pending write still completes its handshake, else busy sticks
                busy_q <= 1'b0;
                if (i_wr_ready) begin
                    o_wr_valid <= 1'b0;
                end
            end else if (o_wr_valid) begin
                if (i_wr_ready) begin
                    o_wr_valid <= 1'b0;
                end
            end else if (busy_q && !o_pop && i_valid) begin
                if (mode_q == `CDM_M_SYNC) begin
                    o_pop <= 1'b1;
                    if (i_status == i_target) begin
                        busy_q <= 1'b0;
                    end
                end else begin
                    addr_q <= addr_q + {29'h0, n_w};
                    rem_q <= rem_q - {{(CW-3){1'b0}}, n_w};
                    off_q <= end_w[1:0];
                    if (end_w >= lim_w) begin
                        o_pop <= 1'b1;
                        off_q <= 2'h0;
                    end
                    if (mode_q == `CDM_M_WRITE) begin
                        o_wr_valid <= 1'b1;
                        o_wr_addr <= {addr_q[31:2], 2'h0};
                        o_wr_data <= i_data;
                        o_wr_be <= lanes(off_q, n_w) & i_be;
                    end
                    if (eol_w && rem_q > {{(CW-3){1'b0}}, n_w}) begin
                        busy_q <= 1'b0;
                        o_early <= 1'b1;
                        o_pop <= 1'b1;
                        off_q <= 2'h0;
                    end else if (rem_q == {{(CW-3){1'b0}}, n_w}) begin
                        busy_q <= 1'b0;
                    end
                end
            end
        end
    end
endmodule
`default_nettype wire

// File: logic/cdm_seq.v
// Purpose: Fetch, decode and sequencing of the capture DMA program
// Assumes: Register port on i_mclk; FIFOs and initiator on i_mclk
// Notes: FIFO1 also carries the merged packed stream
`include "cdm_consts.vh"
`default_nettype none
module cdm_seq (
    // Clock and reset
    input wire i_mclk,
    input wire i_rst,
    // Register port
    input wire [3:0] i_addr,
    input wire [31:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    output reg [31:0] o_rdata,
    // Instruction fetch through the initiator
    output wire o_fetch_req,
    output wire [31:0] o_fetch_addr,
    input wire i_fetch_ack,
    input wire [31:0] i_fetch_data,
    // FIFO heads
    input wire [2:0] i_fifo_valid,
    input wire [95:0] i_fifo_data,
    input wire [11:0] i_fifo_status,
    output wire [2:0] o_fifo_pop,
    // Pixel write requests, one per FIFO
    output wire [2:0] o_wr_valid,
    output wire [95:0] o_wr_addr,
    output wire [95:0] o_wr_data,
    output wire [11:0] o_wr_be,
    input wire [2:0] i_wr_ready,
    // Events
    output reg o_instr_irq,
    output reg o_error_irq
);
    localparam S_IDLE = 3'h0;
    localparam S_FETCH = 3'h1;
    localparam S_WAITF = 3'h2;
    localparam S_EXEC = 3'h3;
    localparam S_RUN = 3'h4;
    localparam S_DONE = 3'h5;
    localparam S_HALT = 3'h6;

    reg [2:0] state_q;
    reg [31:0] pc_q;
    reg [31:0] start_q;
    reg [31:0] iw_q [0:4];
    reg [2:0] widx_q;
    reg [2:0] len_q;
    reg jumped_q;
    reg abort_q;
    reg planar_q;
    reg [3:0] psb_q;
    reg fgo_q;
    reg [2:0] go_q;
    reg [2:0] abort_ch_q;
    reg [1:0] m1_q;
    reg [1:0] m23_q;
    reg [11:0] c1_q;
    reg [11:0] c23_q;
    reg ld_q;
    reg [31:0] a1_q;
    reg [31:0] a2_q;
    reg [31:0] a3_q;
    wire [31:0] fword;
    wire fdone;
    wire [2:0] busy;
    wire [2:0] early;
    wire [3:0] op;
    wire [2:0] flen;
    wire [31:0] w0;

    // Words per opcode; zero marks an illegal opcode
    function [2:0] ilen;
        input [3:0] o;
        begin
            case (o)
                `CDM_OP_WRITE: ilen = 3'h2;
                `CDM_OP_PWRITE: ilen = 3'h5;
                `CDM_OP_LWCS: ilen = 3'h3;
                `CDM_OP_CONT: ilen = 3'h1;
                `CDM_OP_SKIP: ilen = 3'h1;
                `CDM_OP_PSKIP: ilen = 3'h2;
                `CDM_OP_JUMP: ilen = 3'h2;
                `CDM_OP_SYNC: ilen = 3'h2;
                default: ilen = 3'h0;
            endcase
        end
    endfunction

    // Status codes a sync may name
    function stat_ok;
        input [3:0] s;
        begin
            case (s)
                `CDM_ST_PACKED, `CDM_ST_PLANAR, `CDM_ST_SOL,
                `CDM_ST_EVEN_END, `CDM_ST_ODD_END, `CDM_ST_PLAIN,
                4'h1, 4'hD, 4'h9, 4'h5: stat_ok = 1'b1;
                default: stat_ok = 1'b0;
            endcase
        end
    endfunction

    assign w0 = iw_q[0];
    assign op = w0[`CDM_F_OP];
    assign flen = ilen(fword[`CDM_F_OP]);

    cdm_fetch u_fetch (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_go(fgo_q),
        .i_addr(pc_q + {27'h0, widx_q, 2'h0}),
        .o_word(fword),
        .o_done(fdone),
        .o_req(o_fetch_req),
        .o_addr(o_fetch_addr),
        .i_ack(i_fetch_ack),
        .i_data(i_fetch_data)
    );

    // Three channels; FIFO2 and FIFO3 share one count
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : g_ch
            cdm_chan #(.CW(12)) u_chan (
                .i_mclk(i_mclk),
                .i_rst(i_rst),
                .i_start(go_q[g]),
                .i_mode(g == 0 ? m1_q : m23_q),
                .i_count(g == 0 ? c1_q : c23_q),
                .i_load_addr(ld_q),
                .i_addr(g == 0 ? a1_q : (g == 1 ? a2_q : a3_q)),
                .i_be(w0[`CDM_F_BE]),
                .i_target(w0[`CDM_F_STAT]),
                .i_abort(abort_ch_q[g]),
                .i_valid(i_fifo_valid[g]),
                .i_data(i_fifo_data[32*g+31:32*g]),
                .i_status(i_fifo_status[4*g+3:4*g]),
                .o_pop(o_fifo_pop[g]),
                .o_wr_valid(o_wr_valid[g]),
                .o_wr_addr(o_wr_addr[32*g+31:32*g]),
                .o_wr_data(o_wr_data[32*g+31:32*g]),
                .o_wr_be(o_wr_be[4*g+3:4*g]),
                .i_wr_ready(i_wr_ready[g]),
                .o_busy(busy[g]),
                .o_early(early[g])
            );
        end
    endgenerate

    // Register reads answer one cycle after the strobe
    always @(posedge i_mclk) begin
        if (i_rst) begin
            o_rdata <= 32'h00000000;
        end else if (i_rd) begin
            case (i_addr)
                `CDM_REG_CTRL: o_rdata <= {31'h0, state_q != S_IDLE && state_q != S_HALT};
                `CDM_REG_START: o_rdata <= start_q;
                `CDM_REG_STATUS: o_rdata <= {21'h0, w0[`CDM_B_REALIGN], abort_q,
                    planar_q, state_q == S_HALT, state_q, psb_q};
                `CDM_REG_PC: o_rdata <= pc_q;
                default: o_rdata <= 32'h00000000;
            endcase
        end else begin
            o_rdata <= 32'h00000000;
        end
    end

    // Program sequencer
    always @(posedge i_mclk) begin
        if (i_rst) begin
            state_q <= S_IDLE;
            pc_q <= `CDM_RST_START;
            start_q <= `CDM_RST_START;
            widx_q <= 3'h0;
            len_q <= 3'h0;
            jumped_q <= 1'b0;
            abort_q <= 1'b0;
            planar_q <= 1'b0;
            psb_q <= `CDM_RST_PSB;
            fgo_q <= 1'b0;
            go_q <= 3'h0;
            abort_ch_q <= 3'h0;
            m1_q <= `CDM_M_SKIP;
            m23_q <= `CDM_M_SKIP;
            c1_q <= 12'h000;
            c23_q <= 12'h000;
            ld_q <= 1'b0;
            a1_q <= 32'h00000000;
            a2_q <= 32'h00000000;
            a3_q <= 32'h00000000;
            o_instr_irq <= 1'b0;
            o_error_irq <= 1'b0;
            iw_q[0] <= 32'h00000000;
            iw_q[1] <= 32'h00000000;
            iw_q[2] <= 32'h00000000;
            iw_q[3] <= 32'h00000000;
            iw_q[4] <= 32'h00000000;
        end else begin
            fgo_q <= 1'b0;
            go_q <= 3'h0;
            abort_ch_q <= 3'h0;
            o_instr_irq <= 1'b0;
            o_error_irq <= 1'b0;
            if (i_wr && i_addr == `CDM_REG_START) begin
                start_q <= i_wdata;
            end
            // Only a control register write leaves halt
            if (i_wr && i_addr == `CDM_REG_CTRL) begin
                if (i_wdata[0]) begin
                    pc_q <= {start_q[31:2], 2'h0};
                    widx_q <= 3'h0;
                    abort_q <= 1'b0;
                    fgo_q <= 1'b1;
                    state_q <= S_WAITF;
                end else begin
                    abort_ch_q <= 3'h7;
                    state_q <= S_IDLE;
                end
            end else begin
                case (state_q)
                    S_FETCH: begin
                        fgo_q <= 1'b1;
                        state_q <= S_WAITF;
                    end
                    S_WAITF: begin
                        if (fdone) begin
                            iw_q[widx_q] <= fword;
                            if (widx_q == 3'h0) begin
                                len_q <= flen;
                            end
                            if (widx_q == 3'h0 && flen == 3'h0) begin
                                o_error_irq <= 1'b1;
                                state_q <= S_HALT;
                            end else if (widx_q + 3'h1 == (widx_q == 3'h0 ? flen : len_q)) begin
                                state_q <= S_EXEC;
                            end else begin
                                widx_q <= widx_q + 3'h1;
                                state_q <= S_FETCH;
                            end
                        end
                    end
                    S_EXEC: begin
                        jumped_q <= 1'b0;
                        state_q <= S_RUN;
                        ld_q <= 1'b1;
                        c1_q <= w0[`CDM_F_CNT];
                        // One count for both chroma FIFOs
                        c23_q <= iw_q[1][`CDM_F_CNT];
                        a1_q <= iw_q[1];
                        a2_q <= iw_q[3];
                        a3_q <= iw_q[4];
                        m1_q <= `CDM_M_SKIP;
                        m23_q <= `CDM_M_SKIP;
                        if (abort_q && op != `CDM_OP_JUMP && op != `CDM_OP_SYNC) begin
                            // Drop instructions up to line end
                            if (w0[`CDM_B_EOL]) begin
                                abort_q <= 1'b0;
                            end
                            state_q <= S_DONE;
                        end else begin
                            case (op)
                                `CDM_OP_WRITE: begin
                                    m1_q <= `CDM_M_WRITE;
                                    go_q <= 3'h1;
                                end
                                `CDM_OP_CONT: begin
                                    m1_q <= `CDM_M_WRITE;
                                    ld_q <= 1'b0;
                                    go_q <= 3'h1;
                                end
                                `CDM_OP_SKIP: begin
                                    ld_q <= 1'b0;
                                    go_q <= 3'h1;
                                end
                                `CDM_OP_PWRITE: begin
                                    m1_q <= `CDM_M_WRITE;
                                    m23_q <= `CDM_M_WRITE;
                                    a1_q <= iw_q[2];
                                    go_q <= 3'h7;
                                end
                                `CDM_OP_LWCS: begin
                                    m1_q <= `CDM_M_WRITE;
                                    a1_q <= iw_q[2];
                                    go_q <= 3'h7;
                                end
                                `CDM_OP_PSKIP: begin
                                    ld_q <= 1'b0;
                                    go_q <= 3'h7;
                                end
                                `CDM_OP_JUMP: begin
                                    pc_q <= {iw_q[1][31:2], 2'h0};
                                    jumped_q <= 1'b1;
                                    state_q <= S_DONE;
                                end
                                default: begin
                                    if (!stat_ok(w0[`CDM_F_STAT])) begin
                                        o_error_irq <= 1'b1;
                                        state_q <= S_HALT;
                                    end else begin
                                        m1_q <= `CDM_M_SYNC;
                                        m23_q <= `CDM_M_SYNC;
                                        ld_q <= 1'b0;
                                        go_q <= (w0[`CDM_F_STAT] == `CDM_ST_PLANAR) ? 3'h7 : 3'h1;
                                    end
                                end
                            endcase
                        end
                    end
                    S_RUN: begin
                        // Abort siblings; skip on unless line end here
                        if (early != 3'h0) begin
                            abort_ch_q <= 3'h7;
                            if (!w0[`CDM_B_EOL]) begin
                                abort_q <= 1'b1;
                            end
                        end
                        if (go_q == 3'h0 && busy == 3'h0) begin
                            // Format taken from matched FIFO marker
                            if (op == `CDM_OP_SYNC && w0[`CDM_F_STAT] == `CDM_ST_PACKED) begin
                                planar_q <= 1'b0;
                            end
                            if (op == `CDM_OP_SYNC && w0[`CDM_F_STAT] == `CDM_ST_PLANAR) begin
                                planar_q <= 1'b1;
                            end
                            state_q <= S_DONE;
                        end
                    end
                    S_DONE: begin
                        o_instr_irq <= w0[`CDM_B_IRQ];
                        psb_q <= (psb_q & ~w0[`CDM_F_CLR]) | w0[`CDM_F_SET];
                        // Step past this instruction and fetch
                        if (!jumped_q) begin
                            pc_q <= pc_q + {27'h0, len_q, 2'h0};
                        end
                        jumped_q <= 1'b0;
                        widx_q <= 3'h0;
                        state_q <= S_FETCH;
                    end
                    default: begin
                        state_q <= state_q;
                    end
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// File: tb/cdm_seq_props.sv
// Purpose: Port-level properties of the capture DMA sequencer
// Assumes: Single clock domain, synchronous active-high reset
// Notes: FIFO1 lane only; planar lanes are checked neither here nor in the bench
`default_nettype none
module cdm_seq_props (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // Fetch side
    input wire logic o_fetch_req,
    input wire logic [31:0] o_fetch_addr,
    input wire logic i_fetch_ack,
    // FIFO and write side
    input wire logic [2:0] o_fifo_pop,
    input wire logic [2:0] o_wr_valid,
    input wire logic [95:0] o_wr_addr,
    input wire logic [2:0] i_wr_ready,
    // Events
    input wire logic o_instr_irq,
    input wire logic o_error_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    property p_req_hold;
        o_fetch_req && !i_fetch_ack |=> o_fetch_req && $stable(o_fetch_addr);
    endproperty
    a_req_hold: assert property (p_req_hold) else $error("fetch request dropped early");
    property p_req_drop;
        o_fetch_req && i_fetch_ack |=> !o_fetch_req;
    endproperty
    a_req_drop: assert property (p_req_drop) else $error("fetch request kept after ack");
    property p_fetch_align;
        o_fetch_req |-> o_fetch_addr[1:0] == 2'h0;
    endproperty
    a_fetch_align: assert property (p_fetch_align) else $error("fetch address unaligned");
    property p_wr_hold;
        o_wr_valid[0] && !i_wr_ready[0] |=> o_wr_valid[0] && $stable(o_wr_addr[31:0]);
    endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("write request not held");
    property p_wr_align;
        o_wr_valid[0] |-> o_wr_addr[1:0] == 2'h0;
    endproperty
    a_wr_align: assert property (p_wr_align) else $error("write address unaligned");
    property p_pop_pulse;
        o_fifo_pop[0] |=> !o_fifo_pop[0];
    endproperty
    a_pop_pulse: assert property (p_pop_pulse) else $error("pop longer than one cycle");
    property p_halt;
        o_error_irq |=> !o_fetch_req [*8];
    endproperty
    a_halt: assert property (p_halt) else $error("fetching after error halt");
    property p_irq_pulse;
        o_instr_irq |=> !o_instr_irq;
    endproperty
    a_irq_pulse: assert property (p_irq_pulse) else $error("instruction event too long");
    c_irq: cover property (o_instr_irq);
    c_err: cover property (o_error_irq);
    c_wr: cover property (o_wr_valid[0] && i_wr_ready[0]);
endmodule
bind cdm_seq cdm_seq_props cdm_seq_props_inst (.i_mclk, .i_rst, .o_fetch_req, .o_fetch_addr,
    .i_fetch_ack, .o_fifo_pop, .o_wr_valid, .o_wr_addr, .i_wr_ready, .o_instr_irq, .o_error_irq);
`default_nettype wire

// File: tb/cdm_init_model.sv
// Purpose: PCI initiator stand-in holding the program in host memory
// Assumes: Requests held until acknowledged
// Notes: Random wait states; data lines toggle while idle
`default_nettype none
module cdm_init_model (
    // Clock
    input wire logic i_mclk,
    // Fetch and write requests
    input wire logic i_req,
    input wire logic [31:0] i_addr,
    output logic o_ack,
    output logic [31:0] o_data,
    output logic [2:0] o_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] mem [0:7];
    initial begin
        o_ack = 1'b0;
        o_data = 32'h0;
        o_ready = 3'h0;
    end
    always @(posedge i_mclk) begin
        o_ack <= 1'b0;
        o_data <= ~o_data; // Not a stale word when idle
        o_ready <= ($urandom % 2) ? 3'h7 : 3'h0;
        if (i_req && !o_ack && ($urandom % 2)) begin
            o_ack <= 1'b1;
            o_data <= mem[i_addr[4:2]];
        end
    end
endmodule
`default_nettype wire

// File: tb/cdm_seq_tb.sv
// Purpose: Self-checking bench of the capture DMA sequencer
// Assumes: Program at address zero, FIFO1 fed from a table
// Notes: Sync, split write, loop jump, stop, restart onto an illegal opcode
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin failures++; \
    $display("unexpected %0t mismatch", $time); end end
module capture_dma_instruction_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_mclk = 0, i_rst = 1, i_wr = 0, i_rd = 0, i_fetch_ack, o_fetch_req;
    logic o_instr_irq, o_error_irq;
    logic [3:0] i_addr = 4'h0;
    logic [31:0] i_wdata = 32'h0, o_rdata, o_fetch_addr, i_fetch_data, d, v;
    logic [2:0] i_fifo_valid, o_fifo_pop, o_wr_valid, i_wr_ready;
    logic [95:0] i_fifo_data, o_wr_addr, o_wr_data;
    logic [11:0] i_fifo_status, o_wr_be;
    logic [31:0] exp_pc[$] = '{32'h0, 32'h4, 32'h8, 32'hC, 32'h10, 32'h14, 32'h18,
        32'h0, 32'h4, 32'h1C};
    logic [67:0] exp_wr[$];
    int failures = 0, n_checks = 0, n_irq = 0, idx = 0;
    always #10 i_mclk = ~i_mclk;
    // FIFO1: packed marker then one end-of-line word
    assign i_fifo_valid = {2'h0, idx < 2};
    assign i_fifo_status = {8'h0, idx == 0 ? 4'h6 : 4'h1};
    assign i_fifo_data = {64'h0, idx == 1 ? d : ~d};
    cdm_seq cdm_seq_inst (.i_mclk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
        .o_fetch_req, .o_fetch_addr, .i_fetch_ack, .i_fetch_data, .i_fifo_valid,
        .i_fifo_data, .i_fifo_status, .o_fifo_pop, .o_wr_valid, .o_wr_addr, .o_wr_data,
        .o_wr_be, .i_wr_ready, .o_instr_irq, .o_error_irq);
    cdm_init_model cdm_init_model_inst (.i_mclk(i_mclk), .i_req(o_fetch_req),
        .i_addr(o_fetch_addr), .o_ack(i_fetch_ack), .o_data(i_fetch_data), .o_ready(i_wr_ready));
    // Reference of fetch order, data and events
    always @(posedge i_mclk) begin
        if (o_fifo_pop[0]) idx <= idx + 1;
        if (o_instr_irq) n_irq++;
        if (o_fetch_req && i_fetch_ack) `CHK(o_fetch_addr, exp_pc.pop_front())
        if (o_wr_valid[0] && i_wr_ready[0])
            `CHK({o_wr_be[3:0], o_wr_addr[31:0], o_wr_data[31:0]}, exp_wr.pop_front())
    end
    task automatic wr(input logic [3:0] a, input logic [31:0] x);
        @(posedge i_mclk) {i_addr, i_wdata, i_wr} <= {a, x, 1'b1};
        @(posedge i_mclk) i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge i_mclk) {i_addr, i_rd} <= {a, 1'b1};
        @(posedge i_mclk) i_rd <= 1'b0;
        #1 v = o_rdata;
    endtask
    task automatic wrap_up;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        void'($urandom(76888));
        d = $urandom;
        // Two halves of one line word: low lanes, then high lanes at the same word
        exp_wr = '{{4'h3, 32'h100, d}, {4'hC, 32'h100, d}};
        // Sync, line split over write and continue, reserved zero
        // Jump back to start; continue-write never starts a line
        cdm_init_model_inst.mem = '{32'h80000006, 0, 32'h1800F002, 32'h100,
            32'h5503F002, 32'h70000000, 0, 32'hF0000000};
        repeat (8) @(posedge i_mclk);
        i_rst <= 1'b0;
        rd(4'h8);
        `CHK(v[3:0], 4'h0)
        wr(4'h0, 32'h1);
        for (int i = 0; i < 3000 && exp_pc.size() > 1; i++) @(posedge i_mclk);
        repeat (20) @(posedge i_mclk);
        rd(4'h0);
        `CHK(v[0], 1'b1)
        wr(4'h0, 32'h0);
        rd(4'h0);
        `CHK(v[0], 1'b0)
        wr(4'h4, 32'h1C);
        rd(4'h4);
        `CHK(v, 32'h1C)
        $display("loop and stop test done");
        wr(4'h0, 32'h1);
        for (int i = 0; i < 3000 && !o_error_irq; i++) @(posedge i_mclk);
        @(posedge i_mclk);
        $display("program run done");
        `CHK(n_irq, 1)
        `CHK(exp_pc.size(), 0)
        `CHK(exp_wr.size(), 0)
        rd(4'h8);
        `CHK(v[7], 1'b1)
        `CHK(v[3:0], 4'h3)
        rd(4'hC);
        `CHK(v, 32'h1C)
        rd(4'h1);
        `CHK(v, 32'h0)
        $display("register test done");
        wrap_up();
    end
    initial begin
        repeat (5000) @(posedge i_mclk);
        failures++;
        wrap_up();
    end
endmodule
`default_nettype wire
